// ---- core/mtrl_pkg.sv ----
// memory-type range lookup: register indices, field layout, type codes and bus carriers
package mtrl_pkg;

   // register indices seen by the model-specific register read and write instructions
   localparam logic [31:0] IDX_DEF_TYPE = 32'h0000_0040;
   localparam logic [31:0] IDX_FIX_FIRST = 32'h0000_0010;
   localparam logic [31:0] IDX_FIX_LAST = 32'h0000_001A;
   localparam logic [31:0] IDX_VAR_FIRST = 32'h0000_0020;
   localparam logic [31:0] IDX_VAR_LAST = 32'h0000_002F;

   localparam int NUM_FIX = 11;
   localparam int NUM_VAR = 8;

   // field layout
   localparam int TYPE_LSB = 0;
   localparam int TYPE_W = 8;
   localparam int FE_BIT = 10;
   localparam int E_BIT = 11;
   localparam int VALID_BIT = 11;
   localparam int ADDR_LSB = 12;
   localparam int ADDR_W = 24;
   localparam int PADDR_W = 36;

   // reserved bits per register kind
   localparam logic [63:0] DEF_RSVD_MASK = 64'hFFFF_FFFF_FFFF_F300;
   localparam logic [63:0] BASE_RSVD_MASK = 64'hFFFF_FFF0_0000_0F00;
   localparam logic [63:0] MASK_RSVD_MASK = 64'hFFFF_FFF0_0000_07FF;

   // memory-type codes
   localparam logic [7:0] TYPE_UC = 8'h00;
   localparam logic [7:0] TYPE_WC = 8'h01;
   localparam logic [7:0] TYPE_WT = 8'h04;
   localparam logic [7:0] TYPE_WP = 8'h05;
   localparam logic [7:0] TYPE_WB = 8'h06;

   // reset values
   localparam logic [7:0] RST_TYPE = 8'h00;
   localparam logic [63:0] RST_FIX = 64'h0000_0000_0000_0000;
   localparam logic [23:0] RST_ADDR = 24'h00_0000;

   // first megabyte covered by the fixed ranges, as bits 35:20 of the address
   localparam logic [15:0] FIX_AREA_HI = 16'h0000;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [31:0] idx;
      logic [63:0] wdata;
   } mtrl_msr_req_t;

   typedef struct packed {
      logic ack;
      logic fault;
      logic [63:0] rdata;
   } mtrl_msr_rsp_t;

endpackage

// ---- core/mtrl_lookup.sv ----
// memory-type range lookup: range registers, register access port and address resolution
`timescale 1ns/1ps

module mtrl_lookup (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire mtrl_pkg::mtrl_msr_req_t i_req,
   output mtrl_pkg::mtrl_msr_rsp_t o_rsp,
   input wire logic [35:0] i_phys_addr,
   output logic [7:0] o_mem_type
);
   import mtrl_pkg::*;

   logic [7:0] def_type_ff;
   logic fe_ff;
   logic e_ff;
   logic [63:0] fix_ff [NUM_FIX];
   logic [7:0] var_type_ff [NUM_VAR];
   logic [23:0] var_base_ff [NUM_VAR];
   logic [23:0] var_mask_ff [NUM_VAR];
   logic [NUM_VAR-1:0] var_valid_ff;
   mtrl_msr_rsp_t rsp_ff;
   mtrl_msr_rsp_t nxt_rsp;

   function automatic logic legal_type(input logic [7:0] t);
      legal_type = (t == TYPE_UC) || (t == TYPE_WC) || (t == TYPE_WT) ||
                   (t == TYPE_WP) || (t == TYPE_WB);
   endfunction

   function automatic logic is_fix(input logic [31:0] idx);
      is_fix = (idx >= IDX_FIX_FIRST) && (idx <= IDX_FIX_LAST);
   endfunction

   function automatic logic is_var(input logic [31:0] idx);
      is_var = (idx >= IDX_VAR_FIRST) && (idx <= IDX_VAR_LAST);
   endfunction

   // any byte of a fixed register that is not a legal code
   function automatic logic fix_bad(input logic [63:0] v);
      logic bad;
      bad = 1'b0;
      for (int b = 0; b < 8; b++)
      begin
         bad = bad | !legal_type(v[8*b +: 8]);
      end
      fix_bad = bad;
   endfunction

   logic [31:0] fix_off;
   logic [31:0] var_off;
   logic [3:0] fix_sel;
   logic [2:0] var_sel;
   logic var_is_mask;

   assign fix_off = i_req.idx - IDX_FIX_FIRST;
   assign var_off = i_req.idx - IDX_VAR_FIRST;
   assign fix_sel = fix_off[3:0];
   assign var_sel = var_off[3:1];
   assign var_is_mask = var_off[0];

   // write checks: a faulting write changes nothing
   logic wr_fault;
   always_comb
   begin
      wr_fault = 1'b0;
      if (i_req.idx == IDX_DEF_TYPE)
      begin
         wr_fault = !legal_type(i_req.wdata[7:0]) ||
                    ((i_req.wdata & DEF_RSVD_MASK) != '0);
      end
      else if (is_fix(i_req.idx))
      begin
         wr_fault = fix_bad(i_req.wdata);
      end
      else if (is_var(i_req.idx))
      begin
         if (var_is_mask)
         begin
            wr_fault = (i_req.wdata & MASK_RSVD_MASK) != '0;
         end
         else
         begin
            wr_fault = ((i_req.wdata & BASE_RSVD_MASK) != '0) ||
                       !legal_type(i_req.wdata[7:0]);
         end
      end
      else
      begin
         wr_fault = 1'b1;
      end
   end

   logic wr_ok;
   assign wr_ok = i_req.wr && !wr_fault;

   // default-type control register
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         def_type_ff <= RST_TYPE;
         fe_ff <= 1'b0;
         e_ff <= 1'b0;
      end
      else if (wr_ok && (i_req.idx == IDX_DEF_TYPE))
      begin
         def_type_ff <= i_req.wdata[TYPE_LSB +: TYPE_W];
         fe_ff <= i_req.wdata[FE_BIT];
         e_ff <= i_req.wdata[E_BIT];
      end
   end

   // fixed-range registers, eight byte fields each
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         for (int i = 0; i < NUM_FIX; i++)
         begin
            fix_ff[i] <= RST_FIX;
         end
      end
      else if (wr_ok && is_fix(i_req.idx))
      begin
         fix_ff[fix_sel] <= i_req.wdata;
      end
   end

   // variable base/mask pairs
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         var_valid_ff <= '0;
         for (int i = 0; i < NUM_VAR; i++)
         begin
            var_type_ff[i] <= RST_TYPE;
            var_base_ff[i] <= RST_ADDR;
            var_mask_ff[i] <= RST_ADDR;
         end
      end
      else if (wr_ok && is_var(i_req.idx))
      begin
         if (var_is_mask)
         begin
            var_mask_ff[var_sel] <= i_req.wdata[ADDR_LSB +: ADDR_W];
            var_valid_ff[var_sel] <= i_req.wdata[VALID_BIT];
         end
         else
         begin
            var_type_ff[var_sel] <= i_req.wdata[TYPE_LSB +: TYPE_W];
            var_base_ff[var_sel] <= i_req.wdata[ADDR_LSB +: ADDR_W];
         end
      end
   end

   // read data; reserved bits read as zero since they are never stored
   logic [63:0] rd_data;
   logic rd_miss;
   always_comb
   begin
      rd_data = '0;
      rd_miss = 1'b0;
      if (i_req.idx == IDX_DEF_TYPE)
      begin
         rd_data[TYPE_LSB +: TYPE_W] = def_type_ff;
         rd_data[FE_BIT] = fe_ff;
         rd_data[E_BIT] = e_ff;
      end
      else if (is_fix(i_req.idx))
      begin
         rd_data = fix_ff[fix_sel];
      end
      else if (is_var(i_req.idx))
      begin
         if (var_is_mask)
         begin
            rd_data[ADDR_LSB +: ADDR_W] = var_mask_ff[var_sel];
            rd_data[VALID_BIT] = var_valid_ff[var_sel];
         end
         else
         begin
            rd_data[ADDR_LSB +: ADDR_W] = var_base_ff[var_sel];
            rd_data[TYPE_LSB +: TYPE_W] = var_type_ff[var_sel];
         end
      end
      else
      begin
         rd_miss = 1'b1;
      end
   end

   // one answer per request, one cycle later; a write beats a read in the same cycle
   always_comb
   begin
      nxt_rsp = '0;
      if (i_req.wr)
      begin
         nxt_rsp.ack = 1'b1;
         nxt_rsp.fault = wr_fault;
      end
      else if (i_req.rd)
      begin
         nxt_rsp.ack = 1'b1;
         nxt_rsp.fault = rd_miss;
         nxt_rsp.rdata = rd_miss ? 64'h0 : rd_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rsp_ff <= '0;
      end
      else
      begin
         rsp_ff <= nxt_rsp;
      end
   end

   assign o_rsp = rsp_ff;

   // fixed-range lookup within the first megabyte
   logic fix_in_area;
   logic fix_hit;
   logic [3:0] fix_reg;
   logic [2:0] fix_byte;
   logic [63:0] fix_word;
   logic [7:0] fix_type;

   assign fix_in_area = i_phys_addr[35:20] == FIX_AREA_HI;
   always_comb
   begin
      if (!i_phys_addr[19])
      begin
         fix_reg = 4'h0;
         fix_byte = i_phys_addr[18:16];
      end
      else if (!i_phys_addr[18])
      begin
         fix_reg = {3'h0, i_phys_addr[17]} + 4'h1;
         fix_byte = i_phys_addr[16:14];
      end
      else
      begin
         fix_reg = {1'b0, i_phys_addr[17:15]} + 4'h3;
         fix_byte = i_phys_addr[14:12];
      end
   end
   assign fix_word = fix_ff[fix_reg];
   assign fix_type = fix_word[{fix_byte, 3'h0} +: 8];
   assign fix_hit = e_ff && fe_ff && fix_in_area;

   // variable-range matching
   logic [NUM_VAR-1:0] var_hit;
   logic [NUM_VAR-1:0] var_uc;
   logic [7:0] var_type;
   always_comb
   begin
      var_type = TYPE_UC;
      for (int i = NUM_VAR - 1; i >= 0; i--)
      begin
         var_hit[i] = var_valid_ff[i] &&
                      ((i_phys_addr[35:12] & var_mask_ff[i]) ==
                       (var_base_ff[i] & var_mask_ff[i]));
         var_uc[i] = var_type_ff[i] == TYPE_UC;
         if (var_hit[i])
         begin
            var_type = var_type_ff[i];
         end
      end
      // other overlaps are undefined; lowest pair wins there
      if ((var_hit & var_uc) != '0)
      begin
         var_type = TYPE_UC;
      end
   end

   // combinational so a lookup sees a write at the very next edge
   always_comb
   begin
      if (!e_ff)
      begin
         o_mem_type = def_type_ff;
      end
      else if (fix_hit)
      begin
         o_mem_type = fix_type;
      end
      else if (var_hit != '0)
      begin
         o_mem_type = var_type;
      end
      else
      begin
         o_mem_type = def_type_ff;
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   sequence seq_def_write_ok;
      i_req.wr && (i_req.idx == IDX_DEF_TYPE) && legal_type(i_req.wdata[7:0]) &&
      ((i_req.wdata & DEF_RSVD_MASK) == '0);
   endsequence

   sequence seq_ack_clean;
      o_rsp.ack && !o_rsp.fault;
   endsequence

   chk_def_write_taken: assert property (
      seq_def_write_ok |=> seq_ack_clean ##0 (def_type_ff == $past(i_req.wdata[7:0])))
      else $error("legal default write not taken");

   chk_def_bad_type: assert property (
      (i_req.wr && (i_req.idx == IDX_DEF_TYPE) && !legal_type(i_req.wdata[7:0]))
      |=> o_rsp.ack && o_rsp.fault && $stable(def_type_ff))
      else $error("illegal default type not refused");

   chk_def_rsvd_fault: assert property (
      (i_req.wr && (i_req.idx == IDX_DEF_TYPE) && ((i_req.wdata & DEF_RSVD_MASK) != '0))
      |=> o_rsp.fault && $stable(e_ff) && $stable(fe_ff))
      else $error("reserved default bits accepted");

   chk_var_rsvd_fault: assert property (
      (i_req.wr && is_var(i_req.idx) && var_is_mask &&
       ((i_req.wdata & MASK_RSVD_MASK) != '0))
      |=> o_rsp.fault && $stable(var_valid_ff))
      else $error("reserved mask bits accepted");

   chk_global_off: assert property (
      !e_ff |-> o_mem_type == def_type_ff)
      else $error("type not default while disabled");

   chk_fix_64k_low: assert property (
      (e_ff && fe_ff && (i_phys_addr[35:16] == 20'h00000)) |-> o_mem_type == fix_ff[0][7:0])
      else $error("first 64K sub-range type wrong");

   chk_uc_overlap: assert property (
      (e_ff && !fix_hit && ((var_hit & var_uc) != '0)) |-> o_mem_type == TYPE_UC)
      else $error("uncached overlap not uncached");

   chk_no_match_def: assert property (
      (e_ff && !fix_hit && (var_hit == '0)) |-> o_mem_type == def_type_ff)
      else $error("unmatched address not default");

   chk_fix_off_var: assert property (
      (e_ff && !fe_ff && fix_in_area && $onehot(var_hit))
      |-> o_mem_type == var_type_ff[$clog2(var_hit)])
      else $error("variable range ignored in fixed area");

   chk_reset_state: assert property (
      @(posedge i_clk) disable iff (1'b0) !i_rst_n |-> !e_ff && (var_valid_ff == '0))
      else $error("ranges enabled during reset");

endmodule

// ---- tb/mtrl_core_model.sv ----
// processor-core model issuing register read and write instructions
`timescale 1ns/1ps
module mtrl_core_model (
   input wire logic i_clk,
   output mtrl_pkg::mtrl_msr_req_t o_req,
   input wire mtrl_pkg::mtrl_msr_rsp_t i_rsp
);
   import mtrl_pkg::*;
   initial o_req = '0;
   // one whole register per access; request stands for exactly the taking edge,
   // since a held request would be taken again on the next edge
   task automatic xfer(input logic wr, input logic [31:0] idx, input logic [63:0] wd,
      output mtrl_msr_rsp_t rsp);
      @(posedge i_clk);
      o_req <= '{wr: wr, rd: !wr, idx: idx, wdata: wd};
      @(posedge i_clk);
      o_req <= '0;
      // answer launched at the taking edge, read at the next edge before it moves on
      @(posedge i_clk);
      rsp = i_rsp;
   endtask
endmodule

// ---- tb/mtrl_lookup_tb.sv ----
// self-checking bench for the memory-type range lookup
`timescale 1ns/1ps
module mtrl_lookup_tb;
   import mtrl_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b1;
   logic [35:0] i_phys_addr = 36'h0;
   mtrl_msr_req_t req;
   mtrl_msr_rsp_t rsp;
   logic [7:0] mem_type;
   int miscompares = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [7:0] codes [5] = '{TYPE_UC, TYPE_WC, TYPE_WT, TYPE_WP, TYPE_WB};
   logic [19:0] fbase [11] = '{20'h00000, 20'h80000, 20'hA0000, 20'hC0000, 20'hC8000,
      20'hD0000, 20'hD8000, 20'hE0000, 20'hE8000, 20'hF0000, 20'hF8000};

   mtrl_lookup mtrl_lookup_inst (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_req(req),
      .o_rsp(rsp),
      .i_phys_addr(i_phys_addr),
      .o_mem_type(mem_type)
   );

   mtrl_core_model mtrl_core_model_inst (
      .i_clk(i_clk),
      .o_req(req),
      .i_rsp(rsp)
   );

   always #5 i_clk = ~i_clk;

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // whole run needs about 300 cycles
   always @(posedge i_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         miscompares++;
         complete_run();
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic acc(input logic wr, input logic [31:0] idx, input logic [63:0] wd,
      input logic flt, input logic [63:0] exp);
      mtrl_msr_rsp_t r;
      mtrl_core_model_inst.xfer(wr, idx, wd, r);
      chk({62'h0, r.ack, r.fault}, {62'h0, 1'b1, flt});
      // writes and faulting reads answer with zero data
      chk(r.rdata, exp);
   endtask

   task automatic wr(input logic [31:0] idx, input logic [63:0] d, input logic flt);
      acc(1'b1, idx, d, flt, 64'h0);
   endtask

   task automatic rd(input logic [31:0] idx, input logic [63:0] exp);
      acc(1'b0, idx, 64'h0, 1'b0, exp);
   endtask

   // address applied at an edge, result read once it has settled
   task automatic look(input logic [35:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      i_phys_addr <= a;
      #1;
      chk({56'h0, mem_type}, {56'h0, exp});
   endtask

   initial
   begin
      logic [63:0] fx;
      logic [19:0] st;
      // a real falling edge, so the asynchronous reset clears state before the first clock
      i_rst_n <= 1'b0;
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rd(IDX_DEF_TYPE, 64'h0);
      rd(IDX_VAR_FIRST + 32'h1, 64'h0);
      look(36'h0_0001_2345, TYPE_UC);
      foreach (codes[i])
      begin
         wr(IDX_DEF_TYPE, {56'h0, codes[i]}, 1'b0);
         rd(IDX_DEF_TYPE, {56'h0, codes[i]});
         look(36'hF_FFFF_F000, codes[i]);
      end
      wr(IDX_DEF_TYPE, 64'h2, 1'b1);
      wr(IDX_DEF_TYPE, 64'h7, 1'b1);
      wr(IDX_DEF_TYPE, 64'h105, 1'b1);
      wr(IDX_DEF_TYPE, 64'h1005, 1'b1);
      wr(IDX_DEF_TYPE, 64'h8000_0000_0000_0005, 1'b1);
      rd(IDX_DEF_TYPE, {56'h0, TYPE_WB});
      for (int r = 0; r < NUM_FIX; r++)
      begin
         for (int k = 0; k < 8; k++)
            fx[8*k +: 8] = codes[(r + k) % 5];
         wr(IDX_FIX_FIRST + 32'(r), fx, 1'b0);
         rd(IDX_FIX_FIRST + 32'(r), fx);
      end
      look(36'h0, TYPE_WB);
      wr(IDX_DEF_TYPE, 64'h406, 1'b0);
      look(36'h0, TYPE_WB);
      wr(IDX_DEF_TYPE, 64'hC05, 1'b0);
      for (int r = 0; r < NUM_FIX; r++)
         for (int k = 0; k < 8; k++)
         begin
            st = r == 0 ? 20'h10000 : (r < 3 ? 20'h04000 : 20'h01000);
            look({16'h0, fbase[r] + st * 20'(k) + st - 20'h1}, codes[(r + k) % 5]);
         end
      wr(IDX_VAR_FIRST, 64'h6, 1'b0);
      wr(IDX_VAR_FIRST + 32'h1, 64'hF_FC00_0800, 1'b0);
      rd(IDX_VAR_FIRST + 32'h1, 64'hF_FC00_0800);
      look(36'h0_0010_0000, TYPE_WB);
      look(36'h0_0400_0000, TYPE_WP);
      look(36'h0_000F_8000, TYPE_UC);
      wr(IDX_DEF_TYPE, 64'h805, 1'b0);
      look(36'h0_000F_8000, TYPE_WB);
      // higher-numbered uncached pair must still win the overlap
      wr(IDX_VAR_FIRST + 32'h2, 64'h20_0000, 1'b0);
      wr(IDX_VAR_FIRST + 32'h3, 64'hF_FFE0_0800, 1'b0);
      look(36'h0_0030_0000, TYPE_UC);
      look(36'h0_0040_0000, TYPE_WB);
      wr(IDX_VAR_FIRST + 32'h4, 64'h8_0000_0004, 1'b0);
      wr(IDX_VAR_FIRST + 32'h5, 64'hF_0000_1800, 1'b0);
      look(36'h8_0000_0000, TYPE_WT);
      look(36'h8_0000_1000, TYPE_WP);
      look(36'h8_0000_2FFF, TYPE_WT);
      wr(IDX_VAR_FIRST, 64'h106, 1'b1);
      wr(IDX_VAR_FIRST + 32'h1, 64'h1_0000_0000_0800, 1'b1);
      wr(IDX_VAR_FIRST + 32'h1, 64'hF_FC00_0801, 1'b1);
      rd(IDX_VAR_FIRST, 64'h6);
      wr(IDX_VAR_FIRST + 32'h1, 64'hF_FC00_0000, 1'b0);
      look(36'h0_0010_0000, TYPE_WP);
      acc(1'b0, 32'h30, 64'h0, 1'b1, 64'h0);
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      @(posedge i_clk);
      i_rst_n <= 1'b1;
      look(36'h0_0010_0000, TYPE_UC);
      rd(IDX_VAR_FIRST + 32'h3, 64'h0);
      complete_run();
   end
endmodule
